// *** rtl/drx_pkg.sv ***
// Shared constants and types for the decrement-register execution block.
// Assumes a single core clock with one phase per rising clock edge.
package drx_pkg;

  localparam int INSTR_W = 14;
  localparam int DATA_W  = 8;
  localparam int ADDR_W  = 7;
  localparam int PC_W    = 13;
  localparam int DEPTH   = 128;

  // Instruction word fields.
  localparam int OPC_MSB  = 13;
  localparam int OPC_LSB  = 8;
  localparam int DIR_BIT  = 7;
  localparam int ADDR_MSB = 6;
  localparam int ADDR_LSB = 0;

  // Opcodes in the upper six bits.
  localparam logic [5:0] OPC_DEC      = 6'h03;
  localparam logic [5:0] OPC_DEC_SKIP = 6'h0b;

  // Direction bit values.
  localparam logic DIR_TO_W    = 1'b0;
  localparam logic DIR_TO_FILE = 1'b1;

  // Status register layout and reset values.
  localparam int          ZERO_BIT     = 2;
  localparam logic [7:0]  STATUS_RESET = 8'h00;
  localparam logic [7:0]  W_RESET      = 8'h00;
  localparam logic [7:0]  DATA_ZERO    = 8'h00;
  localparam logic [7:0]  DATA_ONE     = 8'h01;
  localparam logic [12:0] PC_RESET     = 13'h0000;
  localparam logic [12:0] PC_STEP      = 13'h0001;
  localparam logic [13:0] INSTR_RESET  = 14'h0000;

  // Instruction cycle phases, Gray coded.
  typedef enum logic [1:0] {
    DRX_Q1 = 2'b00,
    DRX_Q2 = 2'b01,
    DRX_Q3 = 2'b11,
    DRX_Q4 = 2'b10
  } drx_phase_t;

endpackage

// *** rtl/drx_regfile.sv ***
// File register memory with one write port and two registered read ports.
// Assumes writes and reads come from logic on the same clock.
module drx_regfile
  import drx_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk_in,
  input  wire logic              rst_in,
  // Write port
  input  wire logic              wr_en_in,
  input  wire logic [ADDR_W-1:0] wr_addr_in,
  input  wire logic [DATA_W-1:0] wr_data_in,
  // Read port A
  input  wire logic [ADDR_W-1:0] rd_a_addr_in,
  output logic      [DATA_W-1:0] rd_a_data_out,
  // Read port B
  input  wire logic [ADDR_W-1:0] rd_b_addr_in,
  output logic      [DATA_W-1:0] rd_b_data_out
);

  logic [DATA_W-1:0] mem [DEPTH];

  always_ff @(posedge core_clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_a_data_out <= DATA_ZERO;
      rd_b_data_out <= DATA_ZERO;
    end else begin
      rd_a_data_out <= mem[rd_a_addr_in];
      rd_b_data_out <= mem[rd_b_addr_in];
    end
  end

endmodule

// *** rtl/drx_core.sv ***
// Execution logic for the decrement and decrement-skip-if-zero instructions.
// Assumes the instruction word is valid on instr_in while take is high (Q1).
module drx_core
  import drx_pkg::*;
(
  // Clock and reset
  input  wire logic               core_clk_in,
  input  wire logic               rst_in,
  // Instruction feed
  input  wire logic [INSTR_W-1:0] instr_in,
  output logic                    instr_take_out,
  // File register preload and inspection
  input  wire logic               preload_we_in,
  input  wire logic [ADDR_W-1:0]  preload_addr_in,
  input  wire logic [DATA_W-1:0]  preload_data_in,
  input  wire logic [ADDR_W-1:0]  peek_addr_in,
  output logic      [DATA_W-1:0]  peek_data_out,
  // Core state
  output logic      [DATA_W-1:0]  w_out,
  output logic      [7:0]         status_out,
  output logic      [PC_W-1:0]    pc_out,
  output logic      [1:0]         phase_out,
  output logic                    nop_cycle_out,
  output logic                    cycle_done_out
);

  ////////////////////////////////////////////////////////////////////////////
  // State.

  drx_phase_t        phase;
  drx_phase_t        next_phase;
  logic [13:0]       ir;
  logic [13:0]       next_ir;
  logic              is_dec;
  logic              next_is_dec;
  logic              is_skip;
  logic              next_is_skip;
  logic              in_nop;
  logic              next_in_nop;
  logic              skip_pend;
  logic              next_skip_pend;
  logic [DATA_W-1:0] result;
  logic [DATA_W-1:0] next_result;
  logic [DATA_W-1:0] w;
  logic [DATA_W-1:0] next_w;
  logic [7:0]        status;
  logic [7:0]        next_status;
  logic [PC_W-1:0]   pc;
  logic [PC_W-1:0]   next_pc;
  logic              done;
  logic              next_done;

  logic              core_we;
  logic              mem_we;
  logic [ADDR_W-1:0] mem_waddr;
  logic [DATA_W-1:0] mem_wdata;
  logic [DATA_W-1:0] rd_data;
  logic [5:0]        opc;

  ////////////////////////////////////////////////////////////////////////////
  // File register memory.

  drx_regfile u_regfile (
    .core_clk_in   (core_clk_in),
    .rst_in        (rst_in),
    .wr_en_in      (mem_we),
    .wr_addr_in    (mem_waddr),
    .wr_data_in    (mem_wdata),
    .rd_a_addr_in  (ir[ADDR_MSB:ADDR_LSB]),
    .rd_a_data_out (rd_data),
    .rd_b_addr_in  (peek_addr_in),
    .rd_b_data_out (peek_data_out)
  );

  // Core write in Q4 has priority over a preload in the same clock.
  always_comb begin
    core_we = 1'b0;
    if (phase == DRX_Q4 && (is_dec || is_skip) && ir[DIR_BIT] == DIR_TO_FILE) begin
      core_we = 1'b1;
    end
    mem_we    = core_we | preload_we_in;
    mem_waddr = core_we ? ir[ADDR_MSB:ADDR_LSB] : preload_addr_in;
    mem_wdata = core_we ? result : preload_data_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase sequencing and execution.

  assign opc = instr_in[OPC_MSB:OPC_LSB];

  // Sequencing group: phase, instruction word and skip bookkeeping.
  always_comb begin
    next_phase     = phase;
    next_ir        = ir;
    next_is_dec    = is_dec;
    next_is_skip   = is_skip;
    next_in_nop    = in_nop;
    next_skip_pend = skip_pend;
    case (phase)
      DRX_Q1: begin
        next_phase     = DRX_Q2;
        next_ir        = instr_in;
        next_in_nop    = skip_pend;
        next_is_dec    = !skip_pend && opc == OPC_DEC;
        next_is_skip   = !skip_pend && opc == OPC_DEC_SKIP;
        next_skip_pend = 1'b0;
      end
      DRX_Q2: begin
        next_phase = DRX_Q3;
      end
      DRX_Q3: begin
        next_phase = DRX_Q4;
      end
      DRX_Q4: begin
        next_phase = DRX_Q1;
        if (is_skip && result == DATA_ZERO) begin
          next_skip_pend = 1'b1;
        end
      end
      default: begin
        next_phase = DRX_Q1;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      phase     <= DRX_Q1;
      ir        <= INSTR_RESET;
      is_dec    <= 1'b0;
      is_skip   <= 1'b0;
      in_nop    <= 1'b0;
      skip_pend <= 1'b0;
    end else begin
      phase     <= next_phase;
      ir        <= next_ir;
      is_dec    <= next_is_dec;
      is_skip   <= next_is_skip;
      in_nop    <= next_in_nop;
      skip_pend <= next_skip_pend;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data path: result, working register, status and counter.

  always_comb begin
    next_result = result;
    next_w      = w;
    next_status = status;
    next_pc     = pc;
    next_done   = 1'b0;
    case (phase)
      DRX_Q3: begin
        next_result = rd_data - DATA_ONE;
      end
      DRX_Q4: begin
        next_done = 1'b1;
        next_pc   = pc + PC_STEP;
        if ((is_dec || is_skip) && ir[DIR_BIT] == DIR_TO_W) begin
          next_w = result;
        end
        if (is_dec) begin
          next_status[ZERO_BIT] = (result == DATA_ZERO);
        end
      end
      default: begin
        next_done = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      result <= DATA_ZERO;
      w      <= W_RESET;
      status <= STATUS_RESET;
      pc     <= PC_RESET;
      done   <= 1'b0;
    end else begin
      result <= next_result;
      w      <= next_w;
      status <= next_status;
      pc     <= next_pc;
      done   <= next_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign instr_take_out = (phase == DRX_Q1);
  assign w_out          = w;
  assign status_out     = status;
  assign pc_out         = pc;
  assign phase_out      = phase;
  // No-operation cycle in place of the skipped word.
  assign nop_cycle_out  = in_nop;
  assign cycle_done_out = done;

endmodule

// *** bench/drx_core_asserts.sv ***
// Concurrent checks on the ports of the decrement execution core.
// Assumes one clock and an asynchronous active-high reset.
module drx_core_asserts
  import drx_pkg::*;
(
  input wire logic               core_clk_in,
  input wire logic               rst_in,
  input wire logic [INSTR_W-1:0] instr_in,
  input wire logic               instr_take_out,
  input wire logic [DATA_W-1:0]  w_out,
  input wire logic [7:0]         status_out,
  input wire logic [PC_W-1:0]    pc_out,
  input wire logic [1:0]         phase_out,
  input wire logic               nop_cycle_out,
  input wire logic               cycle_done_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////////////////////////////////////////////
  AST_PHASE_ORDER: assert property (phase_out == 2'b00 |=> phase_out == 2'b01 ##1
    phase_out == 2'b11 ##1 phase_out == 2'b10 ##1 phase_out == 2'b00) else $error("phase order");
  AST_TAKE_Q1: assert property (instr_take_out == (phase_out == 2'b00))
    else $error("take outside Q1");
  AST_PC_STEP: assert property (phase_out == 2'b10 |=> pc_out == $past(pc_out) + PC_STEP)
    else $error("pc step");
  AST_PC_HOLD: assert property (phase_out != 2'b10 |=> $stable(pc_out))
    else $error("pc moved");
  AST_DONE_AFTER_Q4: assert property (cycle_done_out |-> $past(phase_out) == 2'b10)
    else $error("done pulse");
  AST_ZERO_FLAG: assert property (instr_take_out && instr_in[13:8] == OPC_DEC &&
    !instr_in[7] ##1 !nop_cycle_out |-> ##3 status_out[ZERO_BIT] == (w_out == DATA_ZERO))
    else $error("zero flag");
  AST_FILE_DEST: assert property (instr_take_out && instr_in[13:8] == OPC_DEC &&
    instr_in[7] ##1 !nop_cycle_out |-> ##3 $stable(w_out)) else $error("w written");
  AST_SKIP_STATUS: assert property (instr_take_out && instr_in[13:8] == OPC_DEC_SKIP
    ##1 !nop_cycle_out |-> ##3 $stable(status_out)) else $error("skip status");
  AST_SKIP_NEXT: assert property (instr_take_out && instr_in[13:8] == OPC_DEC_SKIP &&
    !instr_in[7] ##1 !nop_cycle_out |-> ##4 nop_cycle_out == ($past(w_out) == DATA_ZERO))
    else $error("skip choice");
  AST_NOP_QUIET: assert property (nop_cycle_out && phase_out == 2'b10 |=>
    $stable(w_out) && $stable(status_out)) else $error("nop changed state");
endmodule
bind drx_core drx_core_asserts u_drx_core_asserts (.core_clk_in(core_clk_in), .rst_in(rst_in),
  .instr_in(instr_in), .instr_take_out(instr_take_out), .w_out(w_out), .status_out(status_out),
  .pc_out(pc_out), .phase_out(phase_out), .nop_cycle_out(nop_cycle_out),
  .cycle_done_out(cycle_done_out));

// *** bench/drx_core_tb_top.sv ***
// Self-checking bench for the decrement execution core.
// Assumes the core runs no-op words whenever no scenario feeds it.
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module drx_core_tb_top;
  import drx_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic               core_clk_in = 1'b0;
  logic               rst_in = 1'b1;
  logic [INSTR_W-1:0] instr_in = INSTR_RESET;
  logic               preload_we_in = 1'b0;
  logic [ADDR_W-1:0]  preload_addr_in = 7'h00;
  logic [DATA_W-1:0]  preload_data_in = 8'h00;
  logic [ADDR_W-1:0]  peek_addr_in = 7'h00;
  logic [DATA_W-1:0]  peek_data_out, w_out;
  logic [7:0]         status_out;
  logic [PC_W-1:0]    pc_out;
  logic [1:0]         phase_out;
  logic               instr_take_out, nop_cycle_out, cycle_done_out;
  int                 n_mismatch = 0, check_count = 0, cyc = 0;
  always #2 core_clk_in = ~core_clk_in;
  drx_core u_drx_core (.core_clk_in(core_clk_in), .rst_in(rst_in), .instr_in(instr_in),
    .instr_take_out(instr_take_out), .preload_we_in(preload_we_in),
    .preload_addr_in(preload_addr_in), .preload_data_in(preload_data_in),
    .peek_addr_in(peek_addr_in), .peek_data_out(peek_data_out), .w_out(w_out),
    .status_out(status_out), .pc_out(pc_out), .phase_out(phase_out),
    .nop_cycle_out(nop_cycle_out), .cycle_done_out(cycle_done_out));
  ////////////////////////////////////////////////////////////////////////////////
  task close_out;
    $display("Checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task sync;
    while (instr_take_out !== 1'b1) @(negedge core_clk_in);
  endtask
  task ld(input logic [6:0] a, input logic [7:0] d);
    @(negedge core_clk_in);
    {preload_we_in, preload_addr_in, preload_data_in} = {1'b1, a, d};
    @(negedge core_clk_in);
    preload_we_in = 1'b0;
  endtask
  task chk_f(input logic [6:0] a, input logic [7:0] e);
    peek_addr_in = a;
    @(negedge core_clk_in);
    `CHK("file", e, peek_data_out)
  endtask
  task op(input logic [13:0] i, input logic [7:0] w_e, input logic z_e, input logic n_e);
    logic [12:0] p;
    sync;
    p = pc_out;
    instr_in = i;
    @(negedge core_clk_in);
    `CHK("nop", n_e, nop_cycle_out)
    instr_in = INSTR_RESET;
    sync;
    `CHK("pc", p + PC_STEP, pc_out)
    `CHK("done", 1'b1, cycle_done_out)
    `CHK("w", w_e, w_out)
    `CHK("status", 8'(z_e) << ZERO_BIT, status_out)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // plain decrement.
  task s_dec;
    ld(7'h10, 8'h13);
    op({OPC_DEC, DIR_TO_W, 7'h10}, 8'h12, 1'b0, 1'b0);
    chk_f(7'h10, 8'h13);
    ld(7'h7f, 8'h01);
    op({OPC_DEC, DIR_TO_FILE, 7'h7f}, 8'h12, 1'b1, 1'b0);
    chk_f(7'h7f, 8'h00);
    ld(7'h11, 8'h01);
    op({OPC_DEC, DIR_TO_W, 7'h11}, 8'h00, 1'b1, 1'b0);
    ld(7'h00, 8'h00);
    op({OPC_DEC, DIR_TO_W, 7'h00}, 8'hff, 1'b0, 1'b0);
  endtask
  task s_skip;
    ld(7'h06, 8'h03);
    ld(7'h05, 8'h01);
    op({OPC_DEC, DIR_TO_FILE, 7'h7f}, 8'hff, 1'b0, 1'b0);
    op({OPC_DEC_SKIP, DIR_TO_W, 7'h06}, 8'h02, 1'b0, 1'b0);
    op({OPC_DEC, DIR_TO_W, 7'h10}, 8'h12, 1'b0, 1'b0);
    op({OPC_DEC_SKIP, DIR_TO_FILE, 7'h05}, 8'h12, 1'b0, 1'b0);
    op({OPC_DEC, DIR_TO_W, 7'h06}, 8'h12, 1'b0, 1'b1);
    chk_f(7'h05, 8'h00);
    ld(7'h07, 8'h01);
    op({OPC_DEC_SKIP, DIR_TO_W, 7'h07}, 8'h00, 1'b0, 1'b0);
    op({OPC_DEC, DIR_TO_W, 7'h06}, 8'h00, 1'b0, 1'b1);
  endtask
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      close_out;
    end
  end
  initial begin
    repeat (4) @(negedge core_clk_in);
    rst_in = 1'b0;
    s_dec;
    s_skip;
    close_out;
  end
endmodule
